// [canopen_nmt_pdo_trigger_test.sv]
// Self-checking bench for the NMT slave and PDO trigger block
`timescale 1ns/1ps
`default_nettype none
module canopen_nmt_pdo_trigger_test;
  import cnpt_pkg::*;
  logic core_clk_i = 0, reset_i = 1, sdo_req_i = 0, cfg_wr_i = 0, cfg_rx_i = 0, e;
  logic nmt_valid_i, sync_valid_i, tx_valid_o, tx_ready_i, sdo_accept_o, cfg_err_o;
  logic [10:0] nmt_cob_i, tx_cob_o, sync_cob_i = CNPT_COB_SYNC;
  cnpt_cmd_type nmt_cmd_i;
  logic [3:0] tx_change_i = 0, tx_mfr_evt_i = 0, tx_rtr_i = 0, rx_pdo_i = 0, map_cnt_o;
  logic [3:0] rx_accept_o, rx_refresh_o, tx_refresh_o;
  logic [2:0] cfg_sel_i = 0;
  logic [1:0] cfg_pdo_i = 0, tx_pdo_o, nmt_state_o;
  logic [15:0] cfg_data_i = 0, map_idx_o;
  int miscompares = 0, n_compared = 0, n;
  cnpt_top dut (.*);
  cnpt_master_model mst (.core_clk_i(core_clk_i), .tx_valid_i(tx_valid_o), .tx_cob_i(tx_cob_o),
    .tx_ready_o(tx_ready_i), .nmt_valid_o(nmt_valid_i), .nmt_cob_o(nmt_cob_i),
    .nmt_cmd_o(nmt_cmd_i), .sync_valid_o(sync_valid_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_compared++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic cyc(input int k); repeat (k) @(negedge core_clk_i); endtask : cyc
  // Configuration write; error pulse caught over two cycles
  task automatic cfg(input logic [2:0] s, input logic r, input logic [1:0] p, input logic [15:0] d);
    @(negedge core_clk_i);
    {cfg_wr_i, cfg_sel_i, cfg_rx_i, cfg_pdo_i, cfg_data_i} = {1'b1, s, r, p, d};
    @(negedge core_clk_i);
    cfg_wr_i = 0;
    e = cfg_err_o;
    @(negedge core_clk_i);
    e = e | cfg_err_o;
  endtask : cfg
  // Drive triggers for one cycle, then count frames taken
  task automatic pulse(input logic [3:0] chg, input logic [3:0] rtr, input logic [3:0] rx);
    n = mst.n_got;
    {tx_change_i, tx_rtr_i, rx_pdo_i} = {chg, rtr, rx};
    cyc(1);
    {tx_change_i, tx_rtr_i, rx_pdo_i} = 12'h000;
    cyc(25);
  endtask : pulse
  task automatic t_boot();
    chk(nmt_state_o, CNPT_ST_INIT);
    cyc(CNPT_INIT_CYC + 5);
    chk(nmt_state_o, CNPT_ST_PREOP);
    chk(sdo_accept_o, 1);
    for (int i = 0; i < 8; i++) begin
      {cfg_rx_i, cfg_pdo_i} = i[2:0];
      cyc(2);
      chk(map_cnt_o, i[1:0] == 0 ? CNPT_MAP_CNT_DIG : CNPT_MAP_CNT_ANA);
      chk(map_idx_o, i[2] ? (i[1:0] == 0 ? CNPT_IDX_DIG_OUT : CNPT_IDX_ANA_OUT)
                          : (i[1:0] == 0 ? CNPT_IDX_DIG_IN : CNPT_IDX_ANA_IN));
    end
    $display("test boot and default mapping done");
  endtask : t_boot
  task automatic t_preop();
    pulse(4'hf, 4'h0, 4'hf);
    chk(mst.n_got - n, 0);
    for (int i = 0; i < 4; i++) begin
      cfg(CNPT_CFG_TT, i[1], 2'd1, i[1] ? 16'h00fc + i[0] : 16'h00f1 + 16'd10 * i[0]);
      chk(e, 1);
    end
    cfg(CNPT_CFG_TT, 0, 2'd3, 16'h00fd);
    chk(e, 0);
    cfg(CNPT_CFG_TT, 0, 2'd2, 16'h0003);
    chk(e, 0);
    $display("test preoperational done");
  endtask : t_preop
  task automatic t_oper();
    mst.wait_n = 3;
    mst.send_cmd(CNPT_CMD_START);
    cyc(2);
    chk(nmt_state_o, CNPT_ST_OPER);
    pulse(4'h2, 4'h0, 4'h8);
    chk(mst.n_got - n, 1);
    chk(mst.last_cob, CNPT_COB_TX_BASE + CNPT_COB_STEP);
    pulse(4'h0, 4'h8, 4'h0);
    chk(mst.n_got - n, 1);
    chk(mst.last_cob, CNPT_COB_TX_BASE + 3 * CNPT_COB_STEP);
    n = mst.n_got;
    for (int i = 1; i <= 3; i++) begin
      mst.send_sync();
      cyc(30);
      chk(mst.n_got - n, i / 3);
    end
    chk(mst.last_cob, CNPT_COB_TX_BASE + 2 * CNPT_COB_STEP);
    $display("test operational done");
  endtask : t_oper
  task automatic t_stop();
    mst.send_cmd(CNPT_CMD_STOP);
    cyc(3);
    chk(nmt_state_o, CNPT_ST_STOPPED);
    chk(sdo_accept_o, 0);
    pulse(4'hf, 4'hf, 4'hf);
    chk(mst.n_got - n, 0);
    mst.send_cmd(CNPT_CMD_RST_COMM);
    cyc(2);
    chk(nmt_state_o, CNPT_ST_INIT);
    cyc(CNPT_INIT_CYC + 5);
    chk(nmt_state_o, CNPT_ST_PREOP);
    $display("test stop and reset done");
  endtask : t_stop
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Run is near 470 cycles; watchdog allows about ten times that
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    cyc(12);
    reset_i = 0;
    t_boot();
    t_preop();
    t_oper();
    t_stop();
    report_and_stop();
  end
endmodule : canopen_nmt_pdo_trigger_test
`default_nettype wire

// [cnpt_checker.sv]
// Port-level assertion checker for the NMT slave and PDO trigger block
`timescale 1ns/1ps
`default_nettype none
module cnpt_checker
  import cnpt_pkg::*;
#(parameter int unsigned NPDO = 4) (
  input wire logic                   core_clk_i, reset_i, nmt_valid_i, cfg_wr_i, cfg_rx_i,
  input wire logic                   tx_valid_o, tx_ready_i, sdo_accept_o, cfg_err_o,
  input wire logic [10:0]            nmt_cob_i, tx_cob_o,
  input wire cnpt_pkg::cnpt_cmd_type nmt_cmd_i,
  input wire logic [NPDO-1:0]        rx_pdo_i, rx_accept_o,
  input wire logic [2:0]             cfg_sel_i,
  input wire logic [15:0]            cfg_data_i,
  input wire logic [1:0]             tx_pdo_o, nmt_state_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Commands only count once initialization has finished
  logic cmd_ok;
  logic typ_wr;
  assign cmd_ok = nmt_valid_i && nmt_cob_i == 11'h000 && nmt_state_o != CNPT_ST_INIT;
  assign typ_wr = cfg_wr_i && sdo_accept_o && cfg_sel_i == CNPT_CFG_TT;
  property p_boot; $fell(reset_i) |-> nmt_state_o == CNPT_ST_INIT; endproperty
  a_boot: assert property (p_boot) else $error("not in init after reset");
  property p_auto;
    $past(nmt_state_o) == CNPT_ST_INIT && nmt_state_o != CNPT_ST_INIT |-> nmt_state_o == CNPT_ST_PREOP;
  endproperty
  a_auto: assert property (p_auto) else $error("init left to wrong state");
  property p_start; cmd_ok && nmt_cmd_i == CNPT_CMD_START |-> ##2 nmt_state_o == CNPT_ST_OPER; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_stop; cmd_ok && nmt_cmd_i == CNPT_CMD_STOP |-> ##2 nmt_state_o == CNPT_ST_STOPPED; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_rst;
    cmd_ok && nmt_cmd_i inside {CNPT_CMD_RST_NODE, CNPT_CMD_RST_COMM} |-> ##2 nmt_state_o == CNPT_ST_INIT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset indication ignored");
  // Process data is taken only while operational
  property p_rxgate;
    1'b1 |=> rx_accept_o == ($past(rx_pdo_i) & {NPDO{nmt_state_o == CNPT_ST_OPER}});
  endproperty
  a_rxgate: assert property (p_rxgate) else $error("rx accept wrong");
  property p_sdo; sdo_accept_o == (nmt_state_o inside {CNPT_ST_PREOP, CNPT_ST_OPER}); endproperty
  a_sdo: assert property (p_sdo) else $error("sdo gating wrong");
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_cob_o) && $stable(tx_pdo_o);
  endproperty
  a_hold: assert property (p_hold) else $error("tx request dropped");
  property p_rsv; typ_wr && cfg_data_i[7:0] inside {[CNPT_TT_RSV_LO:CNPT_TT_RSV_HI]} |=> cfg_err_o;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved type taken");
  property p_rxrtr; typ_wr && cfg_rx_i && cfg_data_i[7:0] inside {8'hfc, 8'hfd} |=> cfg_err_o;
  endproperty
  a_rxrtr: assert property (p_rxrtr) else $error("rtr type on rx taken");
endmodule : cnpt_checker
bind cnpt_top cnpt_checker #(.NPDO(NPDO)) u_chk (.*);
`default_nettype wire

// [cnpt_fifo.sv]
// Synchronous valid/ready FIFO for outgoing PDO requests
`timescale 1ns/1ps
`default_nettype none
module cnpt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
  end

  // Honest flags straight from the count
  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage; no reset needed on data
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : cnpt_fifo
`default_nettype wire

// [cnpt_master_model.sv]
// Behavioural network master: NMT broadcast, SYNC producer, frame sink
`timescale 1ns/1ps
`default_nettype none
module cnpt_master_model
  import cnpt_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              tx_valid_i,
  input  wire logic [10:0]       tx_cob_i,
  output logic                   tx_ready_o,
  output logic                   nmt_valid_o,
  output logic [10:0]            nmt_cob_o,
  output cnpt_pkg::cnpt_cmd_type nmt_cmd_o,
  output logic                   sync_valid_o
);
  int          wait_n = 0;
  int          stall = 0;
  int          n_got = 0;
  logic [10:0] last_cob = 11'h7ff;
  initial begin
    tx_ready_o = 1'b0;
    nmt_valid_o = 1'b0;
    nmt_cob_o = 11'h7ff;
    nmt_cmd_o = CNPT_CMD_NONE;
    sync_valid_o = 1'b0;
  end
  // Slow sink: ready only after wait_n cycles of a standing request
  always @(negedge core_clk_i) begin
    stall = tx_valid_i ? stall + 1 : 0;
    tx_ready_o = tx_valid_i && stall > wait_n;
  end
  // Count frames taken at the handshake edge
  always @(posedge core_clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      n_got++;
      last_cob = tx_cob_i;
    end
  end
  // Broadcast command, identifier zero, idle identifier not left stale
  task automatic send_cmd(input cnpt_cmd_type c);
    @(negedge core_clk_i);
    nmt_valid_o = 1'b1;
    nmt_cob_o = 11'h000;
    nmt_cmd_o = c;
    @(negedge core_clk_i);
    nmt_valid_o = 1'b0;
    nmt_cob_o = 11'h7ff;
    nmt_cmd_o = CNPT_CMD_NONE;
  endtask : send_cmd
  task automatic send_sync();
    @(negedge core_clk_i);
    sync_valid_o = 1'b1;
    @(negedge core_clk_i);
    sync_valid_o = 1'b0;
  endtask : send_sync
endmodule : cnpt_master_model
`default_nettype wire

// [cnpt_pkg.sv]
// Package for the NMT slave and PDO trigger block: states, commands, types, constants
package cnpt_pkg;

  // NMT slave states, Gray coded along init -> preop -> oper -> stopped
  typedef enum logic [1:0] {
    CNPT_ST_INIT    = 2'h0,
    CNPT_ST_PREOP   = 2'h1,
    CNPT_ST_OPER    = 2'h3,
    CNPT_ST_STOPPED = 2'h2
  } cnpt_state_type;

  // Management indications, decoded upstream from broadcast frames
  typedef enum logic [2:0] {
    CNPT_CMD_NONE      = 3'h0,
    CNPT_CMD_START     = 3'h1,
    CNPT_CMD_PREOP     = 3'h2,
    CNPT_CMD_STOP      = 3'h3,
    CNPT_CMD_RST_NODE  = 3'h4,
    CNPT_CMD_RST_COMM  = 3'h5
  } cnpt_cmd_type;

  // Transmission type encodings
  localparam logic [7:0] CNPT_TT_ACYC     = 8'h00;
  localparam logic [7:0] CNPT_TT_CYC_MAX  = 8'hf0;
  localparam logic [7:0] CNPT_TT_RSV_LO   = 8'hf1;
  localparam logic [7:0] CNPT_TT_RSV_HI   = 8'hfb;
  localparam logic [7:0] CNPT_TT_RTR_SYNC = 8'hfc;
  localparam logic [7:0] CNPT_TT_RTR_ONLY = 8'hfd;
  localparam logic [7:0] CNPT_TT_MFR_EVT  = 8'hfe;
  localparam logic [7:0] CNPT_TT_DEV_EVT  = 8'hff;
  localparam logic [7:0] CNPT_TT_RESET    = CNPT_TT_DEV_EVT;

  // Object dictionary indices for the default mappings and the SYNC settings
  localparam logic [15:0] CNPT_IDX_DIG_IN   = 16'h6000;
  localparam logic [15:0] CNPT_IDX_DIG_OUT  = 16'h6200;
  localparam logic [15:0] CNPT_IDX_ANA_IN   = 16'h6401;
  localparam logic [15:0] CNPT_IDX_ANA_OUT  = 16'h6411;
  localparam logic [15:0] CNPT_IDX_SYNC_ID  = 16'h1005;
  localparam logic [15:0] CNPT_IDX_CYC_PER  = 16'h1006;
  localparam logic [15:0] CNPT_IDX_SYNC_WIN = 16'h1007;

  // Default mapping counts held at subindex zero
  localparam logic [3:0] CNPT_MAP_CNT_DIG = 4'h8;
  localparam logic [3:0] CNPT_MAP_CNT_ANA = 4'h4;

  // Default identifiers and SYNC id
  localparam logic [10:0] CNPT_COB_TX_BASE = 11'h180;
  localparam logic [10:0] CNPT_COB_RX_BASE = 11'h200;
  localparam logic [10:0] CNPT_COB_STEP    = 11'h100;
  localparam logic [10:0] CNPT_COB_SYNC    = 11'h080;

  // Initialization time and SYNC window defaults
  localparam int unsigned CNPT_CLK_MHZ      = 100;
  localparam int unsigned CNPT_INIT_US      = 1;
  localparam int unsigned CNPT_INIT_CYC     = CNPT_INIT_US * CNPT_CLK_MHZ;
  localparam logic [15:0] CNPT_SYNC_WIN_RST = 16'h03e8;

  // Configuration write selectors
  localparam logic [2:0] CNPT_CFG_TT     = 3'h0;
  localparam logic [2:0] CNPT_CFG_COB    = 3'h1;
  localparam logic [2:0] CNPT_CFG_MAPCNT = 3'h2;
  localparam logic [2:0] CNPT_CFG_MAPIDX = 3'h3;
  localparam logic [2:0] CNPT_CFG_SYNCID = 3'h4;
  localparam logic [2:0] CNPT_CFG_WIN    = 3'h5;
  localparam logic [2:0] CNPT_CFG_PER    = 3'h6;

endpackage : cnpt_pkg

// [cnpt_top.sv]
// NMT slave state machine and PDO transmission trigger control
// Notes on behaviour
// - Receive object 1 defaults to eight digital output bytes, subindices 1-8.
// - Receive objects 2-4 default to four 16-bit analog outputs each.
// - Transmit object 1 defaults to eight digital input bytes, sent on event.
// - Transmit objects 2-4 default to four 16-bit analog inputs, sent on event.
// - Each mapping keeps the mapped object count at subindex zero.
// - Master may rewrite mappings and identifiers at run time.
// - After reset the node enters initialization on its own.
// - Initialization finishing moves the node to preoperational automatically.
// - Five management indications accepted; action depends on current state.
// - Preoperational: SDO served, no process data sent or accepted.
// - Operational: SDO and process data all active.
// - Stopped: both SDO and process data cease.
// - Synchronous transmits go only inside the window after a SYNC.
// - SYNC identifier, cycle period and window length are held separately.
// - Type 0 sends at a SYNC only after an internal event.
// - Types 1-240 send or receive every N SYNC messages.
// - Type 252 refreshes data at SYNC, sends only on remote request.
// - Type 253 refreshes data and sends on remote request only.
// - Types 252 and 253 are refused for receive objects.
// - Type 254 sends on a manufacturer application event.
// - Asynchronous transmits also go on a remote request.
// - Default transmission type is 255, sending whenever mapped data changes.
`timescale 1ns/1ps
`default_nettype none
module cnpt_top
  import cnpt_pkg::*;
#(
  parameter int unsigned NPDO       = 4,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  // Management frame with its identifier, checked here against zero
  input  wire logic                 nmt_valid_i,
  input  wire logic [10:0]          nmt_cob_i,
  input  wire cnpt_pkg::cnpt_cmd_type nmt_cmd_i,
  // Received SYNC frame identifier
  input  wire logic                 sync_valid_i,
  input  wire logic [10:0]          sync_cob_i,
  // Per transmit object triggers
  input  wire logic [NPDO-1:0]      tx_change_i,
  input  wire logic [NPDO-1:0]      tx_mfr_evt_i,
  input  wire logic [NPDO-1:0]      tx_rtr_i,
  // Received process data and SDO requests
  input  wire logic [NPDO-1:0]      rx_pdo_i,
  input  wire logic                 sdo_req_i,
  // Configuration write from the SDO server
  input  wire logic                 cfg_wr_i,
  input  wire logic [2:0]           cfg_sel_i,
  input  wire logic                 cfg_rx_i,
  input  wire logic [1:0]           cfg_pdo_i,
  input  wire logic [15:0]          cfg_data_i,
  // Outgoing PDO requests to the frame layer
  output logic                      tx_valid_o,
  output logic [1:0]                tx_pdo_o,
  output logic [10:0]               tx_cob_o,
  input  wire logic                 tx_ready_i,
  // Status
  output logic [1:0]                nmt_state_o,
  output logic [NPDO-1:0]           rx_accept_o,
  output logic [NPDO-1:0]           rx_refresh_o,
  output logic [NPDO-1:0]           tx_refresh_o,
  output logic                      sdo_accept_o,
  output logic                      cfg_err_o,
  output logic [3:0]                map_cnt_o,
  output logic [15:0]               map_idx_o
);
  import cnpt_pkg::*;

  initial begin
    if (NPDO != 4) $error("NPDO must be 4");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  cnpt_state_type   state_ff;
  logic [7:0]       init_cnt_ff;
  logic [7:0]       tx_tt_ff   [NPDO];
  logic [7:0]       rx_tt_ff   [NPDO];
  logic [7:0]       tx_sync_ff [NPDO];
  logic [7:0]       rx_sync_ff [NPDO];
  logic [10:0]      tx_cob_ff  [NPDO];
  logic [10:0]      rx_cob_ff  [NPDO];
  logic [3:0]       tx_mcnt_ff [NPDO];
  logic [3:0]       rx_mcnt_ff [NPDO];
  logic [15:0]      tx_midx_ff [NPDO];
  logic [15:0]      rx_midx_ff [NPDO];
  logic [NPDO-1:0]  evt_pend_ff;
  logic [NPDO-1:0]  tx_pend_ff;
  logic [10:0]      sync_id_ff;
  logic [15:0]      sync_win_ff;
  logic [15:0]      cyc_per_ff;
  logic [15:0]      win_cnt_ff;
  logic [1:0]       rr_ff;
  logic             pdo_on;
  logic             sync_hit;
  logic             win_open;
  logic [NPDO-1:0]  tx_fire;
  logic [NPDO-1:0]  grant;
  logic [1:0]       grant_idx;
  logic             f_in_valid;
  logic             f_in_ready;
  logic [12:0]      f_out;
  logic             f_out_valid;

  // Reserved encodings 241..251
  function automatic logic tt_reserved(input logic [7:0] tt);
    return (tt >= CNPT_TT_RSV_LO) && (tt <= CNPT_TT_RSV_HI);
  endfunction : tt_reserved

  // Synchronous family: 0..240 and 252
  function automatic logic tt_is_sync(input logic [7:0] tt);
    return (tt <= CNPT_TT_CYC_MAX) || (tt == CNPT_TT_RTR_SYNC);
  endfunction : tt_is_sync

  assign pdo_on   = (state_ff == CNPT_ST_OPER);
  assign sync_hit = sync_valid_i && (sync_cob_i == sync_id_ff);
  assign win_open = (win_cnt_ff != 16'h0000);

  // NMT slave; command only honoured when sent on identifier zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff    <= CNPT_ST_INIT;
      init_cnt_ff <= '0;
    end else begin
      case (state_ff)
        CNPT_ST_INIT: begin
          if (init_cnt_ff == 8'(CNPT_INIT_CYC - 1)) begin
            state_ff    <= CNPT_ST_PREOP;
            init_cnt_ff <= '0;
          end else begin
            init_cnt_ff <= init_cnt_ff + 8'h01;
          end
        end
        default: begin
          if (nmt_valid_i && nmt_cob_i == 11'h000) begin
            case (nmt_cmd_i)
              CNPT_CMD_START:    state_ff <= CNPT_ST_OPER;
              CNPT_CMD_PREOP:    state_ff <= CNPT_ST_PREOP;
              CNPT_CMD_STOP:     state_ff <= CNPT_ST_STOPPED;
              CNPT_CMD_RST_NODE: state_ff <= CNPT_ST_INIT;
              CNPT_CMD_RST_COMM: state_ff <= CNPT_ST_INIT;
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // SYNC window timer reloads on every SYNC and counts down
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      win_cnt_ff <= '0;
    end else if (sync_hit) begin
      win_cnt_ff <= sync_win_ff;
    end else if (win_open) begin
      win_cnt_ff <= win_cnt_ff - 16'h0001;
    end
  end

  // SYNC settings; reset holds init, so defaults load here without a reset branch
  always_ff @(posedge core_clk_i) begin
    if (state_ff == CNPT_ST_INIT) begin
      sync_id_ff  <= CNPT_COB_SYNC;
      sync_win_ff <= CNPT_SYNC_WIN_RST;
      cyc_per_ff  <= '0;
    end else if (cfg_wr_i && sdo_accept_o) begin
      if (cfg_sel_i == CNPT_CFG_SYNCID) sync_id_ff <= cfg_data_i[10:0];
      if (cfg_sel_i == CNPT_CFG_WIN) sync_win_ff <= cfg_data_i;
      if (cfg_sel_i == CNPT_CFG_PER) cyc_per_ff <= cfg_data_i;
    end
  end

  // Configuration errors: reserved types, RTR types on receive objects
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= cfg_wr_i && sdo_accept_o && cfg_sel_i == CNPT_CFG_TT
                   && (tt_reserved(cfg_data_i[7:0])
                       || (cfg_rx_i && cfg_data_i[7:0] >= CNPT_TT_RTR_SYNC
                           && cfg_data_i[7:0] <= CNPT_TT_RTR_ONLY));
    end
  end

  // SDO served in preop and operational, not in stopped or init
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sdo_accept_o <= 1'b0;
    end else begin
      sdo_accept_o <= (state_ff == CNPT_ST_PREOP) || (state_ff == CNPT_ST_OPER);
    end
  end

  // Per object configuration, counters and triggers
  genvar g;
  generate
    for (g = 0; g < NPDO; g++) begin : g_pdo
      logic        cfg_hit;
      logic        bad_tt;
      logic        tx_cyc_due;
      logic        rx_cyc_due;
      assign cfg_hit = cfg_wr_i && sdo_accept_o && cfg_pdo_i == 2'(g);
      assign bad_tt  = tt_reserved(cfg_data_i[7:0])
                       || (cfg_rx_i && cfg_data_i[7:0] >= CNPT_TT_RTR_SYNC
                           && cfg_data_i[7:0] <= CNPT_TT_RTR_ONLY);
      assign tx_cyc_due = tx_tt_ff[g] != CNPT_TT_ACYC && tx_tt_ff[g] <= CNPT_TT_CYC_MAX
                          && tx_sync_ff[g] + 8'h01 >= tx_tt_ff[g];
      assign rx_cyc_due = rx_tt_ff[g] != CNPT_TT_ACYC && rx_tt_ff[g] <= CNPT_TT_CYC_MAX
                          && rx_sync_ff[g] + 8'h01 >= rx_tt_ff[g];

      // Mapping store; defaults load while in init, which reset forces
      always_ff @(posedge core_clk_i) begin
        if (state_ff == CNPT_ST_INIT) begin
          tx_tt_ff[g]   <= CNPT_TT_RESET;
          rx_tt_ff[g]   <= CNPT_TT_RESET;
          tx_cob_ff[g]  <= CNPT_COB_TX_BASE + 11'(g) * CNPT_COB_STEP;
          rx_cob_ff[g]  <= CNPT_COB_RX_BASE + 11'(g) * CNPT_COB_STEP;
          tx_mcnt_ff[g] <= (g == 0) ? CNPT_MAP_CNT_DIG : CNPT_MAP_CNT_ANA;
          rx_mcnt_ff[g] <= (g == 0) ? CNPT_MAP_CNT_DIG : CNPT_MAP_CNT_ANA;
          tx_midx_ff[g] <= (g == 0) ? CNPT_IDX_DIG_IN : CNPT_IDX_ANA_IN;
          rx_midx_ff[g] <= (g == 0) ? CNPT_IDX_DIG_OUT : CNPT_IDX_ANA_OUT;
        end else if (cfg_hit) begin
          case (cfg_sel_i)
            CNPT_CFG_TT: begin
              if (!bad_tt && cfg_rx_i) rx_tt_ff[g] <= cfg_data_i[7:0];
              if (!bad_tt && !cfg_rx_i) tx_tt_ff[g] <= cfg_data_i[7:0];
            end
            CNPT_CFG_COB: begin
              if (cfg_rx_i) rx_cob_ff[g] <= cfg_data_i[10:0];
              else tx_cob_ff[g] <= cfg_data_i[10:0];
            end
            CNPT_CFG_MAPCNT: begin
              if (cfg_rx_i) rx_mcnt_ff[g] <= cfg_data_i[3:0];
              else tx_mcnt_ff[g] <= cfg_data_i[3:0];
            end
            CNPT_CFG_MAPIDX: begin
              if (cfg_rx_i) rx_midx_ff[g] <= cfg_data_i;
              else tx_midx_ff[g] <= cfg_data_i;
            end
            default: ;
          endcase
        end
      end

      // SYNC counters for cyclic types; restart after each due SYNC
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          tx_sync_ff[g] <= '0;
          rx_sync_ff[g] <= '0;
        end else if (!pdo_on) begin
          tx_sync_ff[g] <= '0;
          rx_sync_ff[g] <= '0;
        end else if (sync_hit) begin
          tx_sync_ff[g] <= tx_cyc_due ? 8'h00 : tx_sync_ff[g] + 8'h01;
          rx_sync_ff[g] <= rx_cyc_due ? 8'h00 : rx_sync_ff[g] + 8'h01;
        end
      end

      // Internal event memory for acyclic type; a new event beats the clear
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          evt_pend_ff[g] <= 1'b0;
        end else if (tx_change_i[g]) begin
          evt_pend_ff[g] <= 1'b1;
        end else if (sync_hit || !pdo_on) begin
          evt_pend_ff[g] <= 1'b0;
        end
      end

      // Trigger decode per transmission type
      always_comb begin
        tx_fire[g] = 1'b0;
        if (pdo_on) begin
          if (tx_tt_ff[g] == CNPT_TT_ACYC) tx_fire[g] = sync_hit && evt_pend_ff[g];
          else if (tx_tt_ff[g] <= CNPT_TT_CYC_MAX) tx_fire[g] = sync_hit && tx_cyc_due;
          else if (tx_tt_ff[g] == CNPT_TT_RTR_SYNC) tx_fire[g] = tx_rtr_i[g];
          else if (tx_tt_ff[g] == CNPT_TT_RTR_ONLY) tx_fire[g] = tx_rtr_i[g];
          else if (tx_tt_ff[g] == CNPT_TT_MFR_EVT) tx_fire[g] = tx_mfr_evt_i[g] || tx_rtr_i[g];
          else if (tx_tt_ff[g] == CNPT_TT_DEV_EVT) tx_fire[g] = tx_change_i[g] || tx_rtr_i[g];
        end
      end

      // Refresh strobes and receive acceptance
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          tx_refresh_o[g] <= 1'b0;
          rx_accept_o[g]  <= 1'b0;
          rx_refresh_o[g] <= 1'b0;
        end else begin
          tx_refresh_o[g] <= pdo_on && ((tx_tt_ff[g] == CNPT_TT_RTR_SYNC && sync_hit)
                             || (tx_tt_ff[g] == CNPT_TT_RTR_ONLY && tx_rtr_i[g]));
          rx_accept_o[g]  <= pdo_on && rx_pdo_i[g];
          rx_refresh_o[g] <= pdo_on && sync_hit && (rx_tt_ff[g] == CNPT_TT_ACYC || rx_cyc_due);
        end
      end

      // Pending send; set wins over the grant that clears it
      always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
          tx_pend_ff[g] <= 1'b0;
        end else if (!pdo_on) begin
          tx_pend_ff[g] <= 1'b0;
        end else if (tx_fire[g]) begin
          tx_pend_ff[g] <= 1'b1;
        end else if (grant[g]) begin
          tx_pend_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Round-robin pick of one pending object; synchronous ones wait for the window
  always_comb begin
    grant     = '0;
    grant_idx = rr_ff;
    for (int k = NPDO - 1; k >= 0; k--) begin
      logic [1:0] idx;
      idx = rr_ff + 2'(k);
      if (tx_pend_ff[idx] && (!tt_is_sync(tx_tt_ff[idx]) || win_open || sync_hit)) begin
        grant_idx = idx;
      end
    end
    if (tx_pend_ff[grant_idx] && f_in_ready
        && (!tt_is_sync(tx_tt_ff[grant_idx]) || win_open || sync_hit)) begin
      grant[grant_idx] = 1'b1;
    end
  end

  assign f_in_valid = |grant;

  // Rotate priority after each grant so no object starves
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rr_ff <= '0;
    end else if (f_in_valid) begin
      rr_ff <= grant_idx + 2'h1;
    end
  end

  cnpt_fifo #(
    .WIDTH (13),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_data_i   ({grant_idx, tx_cob_ff[grant_idx]}),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .out_data_o  (f_out),
    .out_valid_o (f_out_valid),
    .out_ready_i (!tx_valid_o)
  );

  // Output stage: one registered request held until taken
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_valid_o <= 1'b0;
      tx_pdo_o   <= '0;
      tx_cob_o   <= '0;
    end else if (tx_valid_o && tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end else if (!tx_valid_o && f_out_valid) begin
      tx_valid_o <= 1'b1;
      tx_pdo_o   <= f_out[12:11];
      tx_cob_o   <= f_out[10:0];
    end
  end

  // Status outputs; mapping view of the object selected by cfg_rx_i and cfg_pdo_i
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      nmt_state_o <= CNPT_ST_INIT;
      map_cnt_o   <= '0;
      map_idx_o   <= '0;
    end else begin
      nmt_state_o <= state_ff;
      map_cnt_o   <= cfg_rx_i ? rx_mcnt_ff[cfg_pdo_i] : tx_mcnt_ff[cfg_pdo_i];
      map_idx_o   <= cfg_rx_i ? rx_midx_ff[cfg_pdo_i] : tx_midx_ff[cfg_pdo_i];
    end
  end
endmodule : cnpt_top
`default_nettype wire
